// File: logic/can_rx_irq_map.vh
// register map, field positions and codes of the receiver interrupt enable block
// assumes byte addressing on an apb bus with 32-bit data, one register per word
`ifndef CAN_RX_IRQ_MAP_VH
`define CAN_RX_IRQ_MAP_VH

// register byte addresses
`define ADDR_RX_IRQ_EN    8'h00
`define ADDR_FLAGS        8'h04
`define ADDR_FLAG_CLEAR   8'h08
`define ADDR_TX_IRQ_EN    8'h0C
`define ADDR_CONTROL      8'h10

// receiver interrupt enable / flag layout
`define BIT_WAKE          7
`define BIT_STATUS_CHG    6
`define RX_STATE_HI       5
`define RX_STATE_LO       4
`define TX_STATE_HI       3
`define TX_STATE_LO       2
`define BIT_OVERRUN       1
`define BIT_RX_FULL       0

// enable bits that initialization mode forces back to reset, sensitivities kept
`define RIE_INIT_MASK     8'hC3
`define RIE_RESET         8'h00
`define TIE_RESET         3'h0
`define TX_BUFFERS        3

// control register layout
`define BIT_INIT_REQ      0
`define BIT_INIT_ACK      1
`define BIT_WAKE_EN       2

// error state codes
`define ST_OK             2'h0
`define ST_WARN           2'h1
`define ST_ERR            2'h2
`define ST_BUSOFF         2'h3

// sensitivity codes
`define SENS_NONE         2'h0
`define SENS_BUSOFF       2'h1
`define SENS_ERR          2'h2
`define SENS_ALL          2'h3

// error counter thresholds
`define LIM_WARN          9'h060
`define LIM_ERR           9'h07F
`define LIM_BUSOFF        9'h0FF

`endif

// File: logic/can_err_state_decode.v
// error counter to error state decoder
// assumes counters come from the bit engine on the same clock
`timescale 1ns/10ps
`include "can_rx_irq_map.vh"

module can_err_state_decode (
  input  wire [8:0] rxErrCount,
  input  wire [8:0] txErrCount,
  output reg  [1:0] rxLevel,
  output reg  [1:0] txLevel
);

  // bus-off only exists for the transmitter; the receiver code mirrors it
  always @* begin
    if (txErrCount > `LIM_BUSOFF) begin
      txLevel = `ST_BUSOFF;
      rxLevel = `ST_BUSOFF;
    end else begin
      if (txErrCount > `LIM_ERR)
        txLevel = `ST_ERR;
      else if (txErrCount > `LIM_WARN)
        txLevel = `ST_WARN;
      else
        txLevel = `ST_OK;
      if (rxErrCount > `LIM_ERR)
        rxLevel = `ST_ERR;
      else if (rxErrCount > `LIM_WARN)
        rxLevel = `ST_WARN;
      else
        rxLevel = `ST_OK;
    end
  end

endmodule // can_err_state_decode

// File: logic/can_state_change_filter.v
// sensitivity filter: decides whether a state change is worth a status-change flag
// assumes old and new state use the shared four-level error state coding
`timescale 1ns/10ps
`include "can_rx_irq_map.vh"

module can_state_change_filter (
  input  wire [1:0] oldState,
  input  wire [1:0] newState,
  input  wire [1:0] sensitivity,
  output reg        hit
);

  wire changed;
  wire busOffEdge;
  wire errEdge;

  assign changed    = (oldState != newState);
  assign busOffEdge = changed & ((oldState == `ST_BUSOFF) | (newState == `ST_BUSOFF));
  // err and bus-off both sit at or above the err code
  assign errEdge    = changed & ((oldState >= `ST_ERR) | (newState >= `ST_ERR));

  always @* begin
    case (sensitivity)
      `SENS_NONE:   hit = 1'h0;
      `SENS_BUSOFF: hit = busOffEdge;
      `SENS_ERR:    hit = errEdge;
      `SENS_ALL:    hit = changed;
      default:      hit = 1'h0;
    endcase
  end

endmodule // can_state_change_filter

// File: logic/can_rx_irq_enable.v
// receiver interrupt enable block of a can controller with its flags and apb slave
// assumes event pulses, counters and init acknowledge come from logic on mclk
//
// Contract
// RQ1: while init requested and acknowledged, enable register is forced to reset contents; the code resets only bits 7, 6, 1 and 0.
// RQ2: enable register always readable; writes ignored while initialization mode is active.
// RQ3: initialization mode leaves both state sensitivity fields untouched.
// RQ4: wake enable bit 7 gates wake events onto the wake interrupt request.
// RQ5: status-change enable bit 6 gates status changes onto the error request.
// RQ6: receiver sensitivity bits 5-4: none, bus-off, error or bus-off, all.
// RQ7: transmitter sensitivity bits 3-2: none, bus-off, error or bus-off, all.
// RQ8: state indications track real state, updated only while no status-change flag.
// RQ9: overrun enable bit 1 gates overrun events onto the error request.
// RQ10: receive-full enable bit 0 gates buffer-full events onto the receive request.
// RQ11: wake needs both wake interrupt enable and control wake enable set.
// RQ12: transmitter leaving bus-off to ok forces receiver state to ok.
// RQ13: host should not read receive buffers while buffer-full flag is clear.
// RQ14: each transmit-empty flag has its own enable in the transmit enable register.
// RQ15: receiver state codes: ok, warning above 96, error above 127, bus-off.
// RQ16: pending status-change flag freezes state indications until software clears it.
// RQ17: each request is flag and enable; error request merges status-change and overrun.
`timescale 1ns/10ps
`include "can_rx_irq_map.vh"

module can_rx_irq_enable (
  input  wire        mclk,
  input  wire        rst_b,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // bit engine side
  input  wire        initAck,
  input  wire        wakeEvent,
  input  wire        overrunEvent,
  input  wire        rxFullEvent,
  input  wire [8:0]  rxErrCount,
  input  wire [8:0]  txErrCount,
  input  wire [2:0]  txEmpty,
  output reg         initRequest,
  // interrupt requests
  output reg         wakeIrq,
  output reg         errIrq,
  output reg         rxIrq,
  output reg         txIrq,
  output reg         irq
);

  // software state
  reg  [7:0] rxIrqEn_q;
  reg  [7:0] rxIrqEn_d;
  reg  [2:0] txIrqEn_q;
  reg  [2:0] txIrqEn_d;
  reg        wakeEnable_q;
  reg        initReq_q;

  // sticky flags and frozen state indications
  reg        wakeFlag_q;
  reg        statusFlag_q;
  reg        overrunFlag_q;
  reg        rxFullFlag_q;
  reg  [1:0] rxState_q;
  reg  [1:0] rxState_d;
  reg  [1:0] txState_q;
  reg  [1:0] txState_d;
  reg        statusSet;
  reg        wakeFlag_d;
  reg        statusFlag_d;
  reg        overrunFlag_d;
  reg        rxFullFlag_d;

  // bus decode
  wire       accessStart;
  wire       accessDone;
  wire       wrDone;
  wire       initMode;
  wire       writeLocked;
  wire       mapped;
  wire       wrRxEn;
  wire       wrTxEn;
  wire       wrCtl;
  wire       wrClr;
  reg  [31:0] readMux;

  // decoded live states and filter results
  wire [1:0] rxLevel;
  wire [1:0] txLevel;
  wire [1:0] rxTarget;
  wire       rxHit;
  wire       txHit;
  wire [7:0] flagWord;
  wire [7:0] clearBits;

  // gated request terms
  wire       wakeTerm;
  wire       statusTerm;
  wire       overrunTerm;
  wire       rxFullTerm;
  wire [2:0] txTerm;
  wire       txAny;

  // one wait state: pready rises in the second access cycle, from a flop
  assign accessStart = psel & penable & ~pready;
  assign accessDone  = psel & penable & pready;
  assign wrDone      = accessDone & pwrite;

  // initialization mode proper needs both request and acknowledge
  assign initMode    = initReq_q & initAck;
  // enable register writes only land when neither request nor acknowledge is set
  assign writeLocked = initReq_q | initAck;

  assign mapped = (paddr == `ADDR_RX_IRQ_EN) | (paddr == `ADDR_FLAGS) |
                  (paddr == `ADDR_FLAG_CLEAR) | (paddr == `ADDR_TX_IRQ_EN) |
                  (paddr == `ADDR_CONTROL);

  // one write strobe per writable register, all tied to the completing access edge
  assign wrRxEn = wrDone & (paddr == `ADDR_RX_IRQ_EN);
  assign wrTxEn = wrDone & (paddr == `ADDR_TX_IRQ_EN);
  assign wrCtl  = wrDone & (paddr == `ADDR_CONTROL);
  assign wrClr  = wrDone & (paddr == `ADDR_FLAG_CLEAR);

  assign clearBits = wrClr ? pwdata[7:0] : 8'h00;

  // flag word shares its layout with the enable register
  assign flagWord = {wakeFlag_q, statusFlag_q, rxState_q, txState_q,
                     overrunFlag_q, rxFullFlag_q};

  // counters to levels
  can_err_state_decode u_decode (
    .rxErrCount (rxErrCount),
    .txErrCount (txErrCount),
    .rxLevel    (rxLevel),
    .txLevel    (txLevel)
  );

  // leaving bus-off is the only exit the transmitter has; drag the receiver along
  assign rxTarget = (txState_q == `ST_BUSOFF && txLevel == `ST_OK) ? `ST_OK : rxLevel; // [RQ12]

  can_state_change_filter u_rx_filter (
    .oldState    (rxState_q),
    .newState    (rxTarget),
    .sensitivity (rxIrqEn_q[`RX_STATE_HI:`RX_STATE_LO]), // [RQ6]
    .hit         (rxHit)
  );

  can_state_change_filter u_tx_filter (
    .oldState    (txState_q),
    .newState    (txLevel),
    .sensitivity (rxIrqEn_q[`TX_STATE_HI:`TX_STATE_LO]), // [RQ7]
    .hit         (txHit)
  );

  // state indications follow the counters only while no status change is pending
  always @* begin
    rxState_d = rxState_q;
    txState_d = txState_q;
    statusSet = 1'h0;
    if (!statusFlag_q) begin // [RQ8] [RQ16]
      rxState_d = rxTarget; // [RQ15]
      txState_d = txLevel;
      statusSet = rxHit | txHit;
    end
  end

  // receiver enable next value: init clears enables but keeps sensitivities
  always @* begin
    rxIrqEn_d = rxIrqEn_q;
    if (initMode)
      rxIrqEn_d = (rxIrqEn_q & ~`RIE_INIT_MASK) | (`RIE_RESET & `RIE_INIT_MASK); // [RQ1] [RQ3]
    else if (wrRxEn && !writeLocked)
      rxIrqEn_d = pwdata[7:0]; // [RQ2]
  end

  // transmitter enable next value, same init behaviour as the receiver one
  always @* begin
    txIrqEn_d = txIrqEn_q;
    if (initMode)
      txIrqEn_d = `TIE_RESET;
    else if (wrTxEn && !writeLocked)
      txIrqEn_d = pwdata[2:0]; // [RQ14]
  end

  // enable registers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxIrqEn_q <= `RIE_RESET;
      txIrqEn_q <= `TIE_RESET;
    end else begin
      rxIrqEn_q <= rxIrqEn_d;
      txIrqEn_q <= txIrqEn_d;
    end
  end

  // control register: init request and wake enable are always writable
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      initReq_q    <= 1'h0;
      wakeEnable_q <= 1'h0;
    end else if (wrCtl) begin
      initReq_q    <= pwdata[`BIT_INIT_REQ];
      wakeEnable_q <= pwdata[`BIT_WAKE_EN];
    end
  end

  // flag next values: a set in the clearing cycle wins, so no event is lost
  always @* begin
    wakeFlag_d    = (wakeEvent & wakeEnable_q) |
                    (wakeFlag_q & ~clearBits[`BIT_WAKE]); // [RQ11]
    statusFlag_d  = statusSet | (statusFlag_q & ~clearBits[`BIT_STATUS_CHG]);
    overrunFlag_d = overrunEvent | (overrunFlag_q & ~clearBits[`BIT_OVERRUN]);
    // the foreground buffer is only valid while this flag stands
    rxFullFlag_d  = rxFullEvent | (rxFullFlag_q & ~clearBits[`BIT_RX_FULL]); // [RQ13]
  end

  // sticky flags, untouched by initialization mode
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wakeFlag_q    <= 1'h0;
      statusFlag_q  <= 1'h0;
      overrunFlag_q <= 1'h0;
      rxFullFlag_q  <= 1'h0;
    end else begin
      wakeFlag_q    <= wakeFlag_d;
      statusFlag_q  <= statusFlag_d;
      overrunFlag_q <= overrunFlag_d;
      rxFullFlag_q  <= rxFullFlag_d;
    end
  end

  // state indications survive initialization mode; only the pin reset clears them
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxState_q <= `ST_OK;
      txState_q <= `ST_OK;
    end else begin
      rxState_q <= rxState_d;
      txState_q <= txState_d;
    end
  end

  // read multiplexer; clear register reads as zero
  always @* begin
    readMux = 32'h00000000;
    case (paddr)
      `ADDR_RX_IRQ_EN: readMux[7:0] = rxIrqEn_q; // [RQ2]
      `ADDR_FLAGS:     readMux[7:0] = flagWord;
      `ADDR_TX_IRQ_EN: readMux[2:0] = txIrqEn_q;
      `ADDR_CONTROL: begin
        readMux[`BIT_INIT_REQ] = initReq_q;
        readMux[`BIT_INIT_ACK] = initAck;
        readMux[`BIT_WAKE_EN]  = wakeEnable_q;
      end
      default:         readMux = 32'h00000000;
    endcase
  end

  // apb answer: data and error captured in the cycle pready rises
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'h0;
      prdata  <= 32'h00000000;
      pslverr <= 1'h0;
    end else begin
      pready  <= accessStart;
      if (accessStart) begin
        prdata  <= pwrite ? 32'h00000000 : readMux;
        pslverr <= ~mapped;
      end else begin
        pslverr <= 1'h0;
      end
    end
  end

  // each request term is its flag gated by its own enable bit
  assign wakeTerm    = wakeFlag_q & rxIrqEn_q[`BIT_WAKE]; // [RQ4] [RQ11] [RQ17]
  assign statusTerm  = statusFlag_q & rxIrqEn_q[`BIT_STATUS_CHG]; // [RQ5]
  assign overrunTerm = overrunFlag_q & rxIrqEn_q[`BIT_OVERRUN]; // [RQ9]
  assign rxFullTerm  = rxFullFlag_q & rxIrqEn_q[`BIT_RX_FULL]; // [RQ10]
  assign txAny       = |txTerm;

  // one enable per transmit buffer, the empty level itself acts as the flag
  genvar gi;
  generate
    for (gi = 0; gi < `TX_BUFFERS; gi = gi + 1) begin : g_tx_term
      assign txTerm[gi] = txEmpty[gi] & txIrqEn_q[gi]; // [RQ14]
    end
  endgenerate

  // requests are registered so each output comes from a flop, one cycle behind
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wakeIrq     <= 1'h0;
      errIrq      <= 1'h0;
      rxIrq       <= 1'h0;
      txIrq       <= 1'h0;
      irq         <= 1'h0;
      initRequest <= 1'h0;
    end else begin
      wakeIrq     <= wakeTerm; // [RQ4] [RQ11] [RQ17]
      errIrq      <= statusTerm | overrunTerm; // [RQ5] [RQ9] [RQ17]
      rxIrq       <= rxFullTerm; // [RQ10] [RQ17]
      txIrq       <= txAny; // [RQ14]
      irq         <= wakeTerm | statusTerm | overrunTerm | rxFullTerm | txAny; // [RQ17]
      initRequest <= initReq_q;
    end
  end

endmodule // can_rx_irq_enable

// File: test/can_rx_irq_enable_props.sv
// port assertions for the receiver interrupt enable block
// assumes an apb master that holds each request until pready
`timescale 1ns/10ps
`include "can_rx_irq_map.vh"
module can_rx_irq_enable_props (
  input wire        mclk,
  input wire        rst_b,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        initRequest,
  input wire [2:0]  txEmpty,
  input wire        wakeIrq,
  input wire        errIrq,
  input wire        rxIrq,
  input wire        txIrq,
  input wire        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // irq is registered from the same terms as the requests, so it matches them exactly
  wire anyReq = wakeIrq | errIrq | rxIrq | txIrq;
  wire ctlWr  = psel & penable & pready & pwrite & (paddr == `ADDR_CONTROL);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long pready");
  a_err_access: assert property (pslverr |-> pready && psel && penable)
    else $error("stray pslverr");
  a_unmapped_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("data on unmapped read");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_init_follow: assert property ($changed(initRequest) |-> $past(ctlWr, 2))
    else $error("init request moved alone");
  a_tx_cause: assert property (txIrq |-> $past(|txEmpty)) else $error("tx request");
  a_irq_cause: assert property (irq == anyReq)
    else $error("irq without request");
  c_wake: cover property (wakeIrq);
  c_err: cover property (errIrq);
  c_unmapped: cover property (pslverr);
endmodule // can_rx_irq_enable_props

bind can_rx_irq_enable can_rx_irq_enable_props u_props (.mclk, .rst_b, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .initRequest, .txEmpty, .wakeIrq, .errIrq,
  .rxIrq, .txIrq, .irq);

// File: test/can_engine_model.sv
// bit engine model: acknowledges initialization requests
// assumes the block's initRequest on the same clock
`timescale 1ns/10ps
module can_engine_model (
  input  wire mclk,
  input  wire rst_b,
  input  wire initRequest,
  output reg  initAck
);
  // ack a cycle late, as an engine waits for a bit boundary
  always @(posedge mclk or negedge rst_b)
    if (!rst_b) initAck <= 1'h0;
    else initAck <= initRequest;
endmodule // can_engine_model

// File: test/tb.sv
// self-checking bench for the receiver interrupt enable block
// assumes the engine model acknowledges init requests
`timescale 1ns/10ps
`include "can_rx_irq_map.vh"
module tb;
  localparam logic [7:0] RIE = `ADDR_RX_IRQ_EN, FLG = `ADDR_FLAGS, CLR = `ADDR_FLAG_CLEAR;
  localparam logic [7:0] TIE = `ADDR_TX_IRQ_EN, CTL = `ADDR_CONTROL;
  logic        mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [2:0]  ev = 3'h0, txEmpty = 3'h0;
  logic [8:0]  cnt [2] = '{9'h000, 9'h000};
  logic        pready, pslverr, initAck, initRequest, err;
  logic        wakeIrq, errIrq, rxIrq, txIrq, irq;
  int          failures = 0, n_tests = 0;
  wire  [2:0]  req = {wakeIrq, errIrq, rxIrq};
  always #4 mclk = ~mclk; // 125 MHz
  can_rx_irq_enable DUT (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .initAck, .wakeEvent(ev[2]), .overrunEvent(ev[1]), .rxFullEvent(ev[0]),
    .rxErrCount(cnt[0]), .txErrCount(cnt[1]), .txEmpty, .initRequest, .wakeIrq, .errIrq,
    .rxIrq, .txIrq, .irq);
  can_engine_model u_engine (.mclk, .rst_b, .initRequest, .initAck);
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one transfer; the request stands until pready is seen at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // read and compare, slave error folded into the top bit
  task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, {err, rdat[30:0]}, {a > CTL, e[30:0]});
  endtask
  task summarize();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // reset values, then forcing and write lock in init mode
  task t_init();
    rd("rie", RIE, {24'h0, `RIE_RESET});
    rd("unmapped", 8'h14, 32'h0);
    apb(1'h1, RIE, 32'hFF);
    apb(1'h1, TIE, 32'h7);
    apb(1'h1, CTL, 32'h1);
    repeat (4) @(posedge mclk);
    chk("initRequest", initRequest, 1'h1);
    rd("control", CTL, 32'h3);
    rd("rie init", RIE, 32'h3C);
    rd("tie init", TIE, 32'h0);
    apb(1'h1, RIE, 32'hC3);
    rd("rie locked", RIE, 32'h3C);
  endtask
  // each event against every mix of its enable and the wake enable
  task t_events();
    int   b;
    logic f;
    for (int i = 0; i < 3; i++)
      for (int m = 0; m < 4; m++) begin
        b = (i == 2) ? 7 : i;
        f = (i != 2) || m[1];
        apb(1'h1, CTL, m[1] ? 32'h4 : 32'h0);
        apb(1'h1, RIE, m[0] ? 32'h1 << b : 32'h0);
        ev[i] <= 1'h1;
        @(posedge mclk);
        ev[i] <= 1'h0;
        repeat (4) @(posedge mclk);
        chk("request", req[i], f & m[0]);
        chk("irq", irq, f & m[0]);
        rd("flag", FLG, f ? 32'h1 << b : 32'h0);
        apb(1'h1, CLR, 32'h1 << b);
      end
  endtask
  // sensitivity per field; a pending flag freezes the states
  task t_state();
    int   sh;
    logic h;
    for (int k = 0; k < 2; k++)
      for (int c = 0; c < 2; c++)
        for (int s = 0; s < 4; s++) begin
          sh = 4 - 2 * k;
          h = c ? s >= 2 : s == 3;
          apb(1'h1, RIE, 32'h40 | s << sh);
          cnt[k] <= c ? 9'h082 : 9'h064;
          repeat (4) @(posedge mclk);
          chk("errIrq", errIrq, h);
          cnt[k] <= 9'h000;
          repeat (4) @(posedge mclk);
          rd("state", FLG, h ? 32'h40 | (c + 1) << sh : 32'h0);
          apb(1'h1, CLR, 32'h40);
          apb(1'h1, CLR, 32'h40);
        end
    // bus-off with transmitter sensitivity 01; receiver counter warns during recovery
    apb(1'h1, RIE, 32'h44);
    cnt[1] <= 9'h100;
    repeat (4) @(posedge mclk);
    chk("busoff errIrq", errIrq, 1'h1);
    rd("busoff", FLG, 32'h7C);
    cnt[1] <= 9'h000;
    cnt[0] <= 9'h064;
    repeat (4) @(posedge mclk);
    apb(1'h1, CLR, 32'h40);
    rd("recover", FLG, 32'h40);
    cnt[0] <= 9'h000;
    apb(1'h1, CLR, 32'h40);
  endtask
  // only an enabled empty buffer raises the transmit request
  task t_tx();
    apb(1'h1, TIE, 32'h2);
    txEmpty <= 3'h5;
    repeat (3) @(posedge mclk);
    chk("txIrq", txIrq, 1'h0);
    txEmpty <= 3'h2;
    repeat (3) @(posedge mclk);
    chk("txIrq", txIrq, 1'h1);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'h1;
    t_init();
    t_events();
    t_state();
    t_tx();
    summarize();
  end
  // watchdog: the sequence needs well under 3000 cycles
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule // tb
